// file: design/pls_pkg.sv
package pls_pkg;
  // Management register addresses
  localparam logic [4:0] REG_CTL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_XO_TEST = 5'h05;
  localparam logic [4:0] REG_XO_CTL = 5'h12;
  localparam logic [4:0] REG_IMP = 5'h13;
  localparam logic [4:0] REG_DS = 5'h14;
  localparam logic [4:0] REG_IPD = 5'h17;
  localparam logic [4:0] REG_INT_EN = 5'h19;
  localparam logic [4:0] REG_INT_STAT = 5'h1a;
  localparam logic [4:0] REG_FMDI = 5'h1b;
  localparam logic [4:0] REG_XO_STAT = 5'h1c;
  localparam logic [4:0] REG_PAGE = 5'h1f;
  // Page select values
  localparam logic [15:0] PAGE_STD = 16'h0000;
  localparam logic [15:0] PAGE_EXT = 16'h0001;
  localparam logic [15:0] PAGE_XO = 16'h2a30;
  // Field positions
  localparam int CTL_SPD_LSB = 6;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_SPD_MSB = 13;
  localparam int STAT_LINK = 2;
  localparam int XO_AUTO_DIS = 5;
  localparam int POL_FIX_DIS = 4;
  localparam int IMP_LSB = 14;
  localparam int DS_EN = 4;
  localparam int DS_SEL_LSB = 2;
  localparam int DS_DONE = 1;
  localparam int IPD_EN = 10;
  localparam int IPD_STAT_LSB = 8;
  localparam int INT_PIN_EN = 15;
  localparam int INT_IPD = 9;
  localparam int FMDI_DIS = 15;
  localparam int XO_FORCE_LSB = 3;
  localparam int XOS_CROSSED = 13;
  localparam int XOS_CD_SWAP = 12;
  localparam int XOS_POL_LSB = 8;
  // Reset values
  localparam logic [15:0] CTL_RST = 16'h1140;
  localparam logic [1:0] IMP_RST = 2'h0;
  // Detection status codes
  localparam logic [1:0] IPD_SEARCH = 2'h0;
  localparam logic [1:0] IPD_FOUND = 2'h1;
  localparam logic [1:0] IPD_NONE = 2'h2;
  // Speed codes, {0.6, 0.13}
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int IPD_TIME_US = 1000;
  localparam int ATTEMPT_TIME_US = 500;
  localparam int IPD_CYC = IPD_TIME_US * CLK_MHZ;
  localparam int ATTEMPT_CYC = ATTEMPT_TIME_US * CLK_MHZ;
  localparam int DS_ATTEMPTS = 2;
  localparam int SYNC_W = 19;
  typedef enum logic [1:0] {
    ST_IPD = 2'b00,
    ST_AN = 2'b01,
    ST_LINK = 2'b10,
    ST_FORCE = 2'b11
  } pls_state_e;
endpackage

// file: design/pls_res_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pls_res_if;
  logic [5:0] our_adv;
  logic [5:0] lp_adv;
  logic lp_master_req;
  logic [1:0] res_speed;
  logic res_fd;
  logic res_master;
  logic res_ok;
  modport core (output our_adv, lp_adv, lp_master_req,
    input res_speed, res_fd, res_master, res_ok);
  modport rsv (input our_adv, lp_adv, lp_master_req,
    output res_speed, res_fd, res_master, res_ok);
endinterface
`default_nettype wire

// file: design/pls_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pls_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Two stages per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          meta <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: design/pls_resolve.sv
`timescale 1ns/1ps
`default_nettype none
module pls_resolve
  import pls_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Resolution channel
  pls_res_if.rsv res
);
  logic [5:0] common;
  assign common = res.our_adv & res.lp_adv;
  // Highest common ability wins: 1000FD, 1000HD, 100FD, 100HD, 10FD, 10HD
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      res.res_speed <= SPD_10;
      res.res_fd <= 1'b0;
      res.res_master <= 1'b0;
      res.res_ok <= 1'b0;
    end
    else
    begin
      res.res_ok <= |common;
      res.res_master <= !res.lp_master_req; // Opposite role to partner
      if (common[5] || common[4])
      begin
        res.res_speed <= SPD_1000;
        res.res_fd <= common[5];
      end
      else if (common[3] || common[2])
      begin
        res.res_speed <= SPD_100;
        res.res_fd <= common[3];
      end
      else
      begin
        res.res_speed <= SPD_10;
        res.res_fd <= common[1];
      end
    end
  end
endmodule
`default_nettype wire

// file: design/pls_core.sv
`timescale 1ns/1ps
`default_nettype none
module pls_core
  import pls_pkg::*;
#(
  parameter int IPD_TIMEOUT = IPD_CYC,
  parameter int ATTEMPT_TIME = ATTEMPT_CYC,
  parameter int DS_COUNT = DS_ATTEMPTS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Management register port
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic mgmt_int,
  // Line front end status (asynchronous)
  input wire logic pma_link,
  input wire logic lp_an_seen,
  input wire logic flp_loop,
  input wire logic crossed_seen,
  input wire logic cd_swap_seen,
  input wire logic [3:0] pair_inv,
  input wire logic [5:0] lp_adv,
  input wire logic lp_master_req,
  input wire logic [1:0] pd_speed,
  input wire logic mac_rgmii_strap,
  // Line front end control
  output logic an_flp_tx,
  output logic ipd_burst_tx,
  output logic [1:0] mdi_mode,
  output logic [3:0] pol_fix,
  output logic master,
  // MAC side
  output logic mac_rgmii,
  output logic [1:0] mac_speed,
  output logic mac_fd,
  output logic [1:0] rx_imp_sel,
  output logic link_up
);
  logic [SYNC_W-1:0] s;
  logic s_link, s_an, s_loop, s_crossed, s_cd, s_mreq, s_strap;
  logic [3:0] s_inv;
  logic [5:0] s_adv;
  logic [1:0] s_pd;
  logic [15:0] ctl;
  logic [15:0] page;
  logic [1:0] xo_ctl;
  logic int_pin_en;
  logic ipd_int;
  logic [1:0] imp_sel;
  logic ds_en;
  logic [1:0] ds_sel;
  logic ds_done;
  logic ipd_en;
  logic [1:0] ipd_stat;
  logic fmdi_dis;
  logic [1:0] xo_force;
  logic strap_done;
  logic [1:0] strap_age;
  logic ipd_hit;
  logic [15:0] next_rdata;
  pls_state_e state;
  logic [15:0] tmr;
  logic [3:0] fail_cnt;
  logic an_en;
  logic pg_std, pg_ext, pg_xo;
  logic rd_int;
  logic auto_xo;
  pls_res_if res ();

  // Every line input is resynchronised in one bank
  pls_sync #(.W(SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({pma_link, lp_an_seen, flp_loop, crossed_seen, cd_swap_seen, pair_inv,
      lp_adv, lp_master_req, pd_speed, mac_rgmii_strap}),
    .q(s)
  );
  assign {s_link, s_an, s_loop, s_crossed, s_cd, s_inv, s_adv, s_mreq, s_pd,
    s_strap} = s;

  pls_resolve u_res (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .res(res.rsv)
  );

  // Advertisement loses both gigabit abilities after downshift
  assign res.our_adv = ds_done ? 6'h0f : 6'h3f;
  assign res.lp_adv = s_adv;
  assign res.lp_master_req = s_mreq;

  // Page decode; page register itself is reachable from every page
  assign pg_std = (page == PAGE_STD);
  assign pg_ext = (page == PAGE_EXT);
  assign pg_xo = (page == PAGE_XO);
  assign an_en = ctl[CTL_AN_EN];
  assign rd_int = rd && pg_std && (addr == REG_INT_STAT);

  // Base control register and page select
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl <= CTL_RST;
      page <= PAGE_STD;
    end
    else if (wr)
    begin
      if (pg_std && addr == REG_CTL)
        ctl <= wdata;
      if (addr == REG_PAGE)
        page <= wdata;
    end
  end

  // Remaining writable configuration, base, extended and crossover test pages
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      xo_ctl <= 2'h0;
      int_pin_en <= 1'b0;
      imp_sel <= IMP_RST;
      ds_en <= 1'b0;
      ds_sel <= 2'h0;
      ipd_en <= 1'b0;
      fmdi_dis <= 1'b0;
      xo_force <= 2'h0;
    end
    else if (wr)
    begin
      if (pg_std && addr == REG_XO_CTL)
        xo_ctl <= wdata[XO_AUTO_DIS -: 2];
      if (pg_std && addr == REG_INT_EN)
        int_pin_en <= wdata[INT_PIN_EN];
      if (pg_ext && addr == REG_IMP)
        imp_sel <= wdata[IMP_LSB +: 2];
      if (pg_ext && addr == REG_DS)
      begin
        ds_en <= wdata[DS_EN];
        ds_sel <= wdata[DS_SEL_LSB +: 2];
      end
      if (pg_ext && addr == REG_IPD)
        ipd_en <= wdata[IPD_EN];
      if (pg_ext && addr == REG_FMDI)
        fmdi_dis <= wdata[FMDI_DIS];
      if (pg_xo && addr == REG_XO_TEST)
        xo_force <= wdata[XO_FORCE_LSB +: 2];
    end
  end

  // Interface mode strap is caught once; wait until the resync stages hold the pin
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_done <= 1'b0;
      strap_age <= 2'h0;
      mac_rgmii <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_age <= strap_age + 2'h1;
      if (strap_age == 2'h2)
      begin
        strap_done <= 1'b1;
        mac_rgmii <= s_strap;
      end
    end
  end

  // Loopback hit raises status and interrupt on the same edge
  assign ipd_hit = an_en && (state == ST_IPD) && s_loop;

  // Detection interrupt: a new hit beats a clearing read
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ipd_int <= 1'b0;
    else if (ipd_hit)
      ipd_int <= 1'b1;
    else if (rd_int)
      ipd_int <= 1'b0;
  end
  assign mgmt_int = ipd_int && int_pin_en;

  // Link setup sequencer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_AN;
      tmr <= 16'h0;
      ipd_stat <= IPD_SEARCH;
      link_up <= 1'b0;
      mac_speed <= SPD_10;
      mac_fd <= 1'b0;
      master <= 1'b0;
    end
    else
    begin
      if (!an_en)
      begin
        // Forced mode follows the control bits every cycle
        state <= ST_FORCE;
        mac_speed <= {ctl[CTL_SPD_LSB], ctl[CTL_SPD_MSB]};
        mac_fd <= ctl[CTL_DUPLEX];
        link_up <= s_link;
        tmr <= 16'h0;
      end
      else
      begin
        unique case (state)
          ST_IPD:
          begin
            link_up <= 1'b0;
            if (s_loop)
            begin
              ipd_stat <= IPD_FOUND;
              state <= ST_AN;
              tmr <= 16'h0;
            end
            else if (32'(tmr) >= IPD_TIMEOUT - 1)
            begin
              ipd_stat <= IPD_NONE;
              state <= ST_AN;
              tmr <= 16'h0;
            end
            else
              tmr <= tmr + 16'h1;
          end
          ST_AN:
          begin
            if (s_link && s_an && res.res_ok)
            begin
              mac_speed <= res.res_speed;
              mac_fd <= res.res_fd;
              master <= res.res_master;
              link_up <= 1'b1;
              state <= ST_LINK;
            end
            else if (s_link && !s_an)
            begin
              mac_speed <= s_pd;
              mac_fd <= 1'b0;
              link_up <= 1'b1;
              state <= ST_LINK;
            end
            else if (s_an && res.res_ok && res.res_speed == SPD_1000)
            begin
              // Gigabit attempt timing; restart after each failure
              if (32'(tmr) >= ATTEMPT_TIME - 1)
                tmr <= 16'h0;
              else
                tmr <= tmr + 16'h1;
            end
            else
              tmr <= 16'h0;
          end
          ST_LINK:
          begin
            if (!s_link)
            begin
              link_up <= 1'b0;
              tmr <= 16'h0;
              if (ipd_en)
              begin
                state <= ST_IPD;
                ipd_stat <= IPD_SEARCH;
              end
              else
                state <= ST_AN;
            end
          end
          ST_FORCE:
          begin
            tmr <= 16'h0;
            if (ipd_en)
            begin
              state <= ST_IPD;
              ipd_stat <= IPD_SEARCH;
            end
            else
              state <= ST_AN;
          end
        endcase
      end
    end
  end

  // Failed gigabit attempts; the count limit is widened by software
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      fail_cnt <= 4'h0;
      ds_done <= 1'b0;
    end
    else if (!ds_en || state == ST_FORCE)
    begin
      fail_cnt <= 4'h0;
      ds_done <= 1'b0;
    end
    else if (state == ST_AN && !s_link && s_an && res.res_ok &&
      res.res_speed == SPD_1000 && 32'(tmr) >= ATTEMPT_TIME - 1)
    begin
      fail_cnt <= fail_cnt + 4'h1;
      if (32'(fail_cnt) + 1 >= DS_COUNT + 32'(ds_sel))
        ds_done <= 1'b1;
    end
  end

  // Crossover and polarity; forced setting overrides crossover detection
  assign auto_xo = !xo_ctl[1] && (an_en || !fmdi_dis);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mdi_mode <= 2'h0;
      pol_fix <= 4'h0;
    end
    else
    begin
      if (xo_force[1])
        mdi_mode <= {1'b0, xo_force[0]};
      else if (auto_xo)
        mdi_mode <= {s_cd, s_crossed};
      else
        mdi_mode <= 2'h0;
      pol_fix <= xo_ctl[0] ? 4'h0 : s_inv;
    end
  end

  assign an_flp_tx = (state == ST_AN) && an_en;
  assign ipd_burst_tx = (state == ST_IPD) && an_en;
  assign rx_imp_sel = imp_sel;

  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0;
    if (addr == REG_PAGE)
      next_rdata = page;
    else if (pg_std)
    begin
      unique case (addr)
        REG_CTL: next_rdata = ctl;
        REG_STAT: next_rdata[STAT_LINK] = link_up;
        REG_XO_CTL: next_rdata[XO_AUTO_DIS -: 2] = xo_ctl;
        REG_INT_EN: next_rdata[INT_PIN_EN] = int_pin_en;
        REG_INT_STAT: next_rdata[INT_IPD] = ipd_int;
        REG_XO_STAT:
        begin
          next_rdata[XOS_CROSSED] = mdi_mode[0];
          next_rdata[XOS_CD_SWAP] = mdi_mode[1];
          next_rdata[XOS_POL_LSB +: 4] = pol_fix;
        end
        default: next_rdata = 16'h0;
      endcase
    end
    else if (pg_ext)
    begin
      unique case (addr)
        REG_IMP: next_rdata[IMP_LSB +: 2] = imp_sel;
        REG_DS: next_rdata[DS_EN:DS_DONE] = {ds_en, ds_sel, ds_done};
        REG_IPD: next_rdata[IPD_EN:IPD_STAT_LSB] = {ipd_en, ipd_stat};
        REG_FMDI: next_rdata[FMDI_DIS] = fmdi_dis;
        default: next_rdata = 16'h0;
      endcase
    end
    else if (pg_xo && addr == REG_XO_TEST)
      next_rdata[XO_FORCE_LSB +: 2] = xo_force;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata <= 16'h0;
    else
      rdata <= next_rdata;
  end

  // Checks
  sequence seq_ipd_hit;
    state == ST_IPD && an_en && s_loop;
  endsequence
  sequence seq_found;
    ipd_stat == IPD_FOUND && ipd_int;
  endsequence

  AST_IPD_LOOP: assert property (@(posedge clk_sys) disable iff (!rstn)
    seq_ipd_hit |=> seq_found ##0 state == ST_AN)
    else $error("loopback did not report found");
  AST_IPD_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == ST_IPD && an_en && !s_loop && 32'(tmr) >= IPD_TIMEOUT - 1
    |=> ipd_stat == IPD_NONE && state == ST_AN)
    else $error("timeout did not report none");
  AST_INT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_int && !ipd_hit |=> !ipd_int && !mgmt_int)
    else $error("read did not clear interrupt");
  AST_INT_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    ipd_int && $past(ipd_int) && !int_pin_en |-> !mgmt_int)
    else $error("interrupt driven while disabled");
  AST_LINK_DROP: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == ST_LINK && an_en && !s_link && ipd_en
    |=> state == ST_IPD && !link_up && ipd_stat == IPD_SEARCH)
    else $error("link loss did not restart detection");
  AST_FORCED: assert property (@(posedge clk_sys) disable iff (!rstn)
    !an_en ##1 !an_en |-> mac_speed == $past({ctl[CTL_SPD_LSB], ctl[CTL_SPD_MSB]})
    && mac_fd == $past(ctl[CTL_DUPLEX]))
    else $error("forced speed not applied");
  AST_DOWNSHIFT: assert property (@(posedge clk_sys) disable iff (!rstn)
    ds_done |-> res.our_adv[5:4] == 2'h0 && $past(ds_en))
    else $error("gigabit still advertised");
  AST_XO_FORCE: assert property (@(posedge clk_sys) disable iff (!rstn)
    xo_force == 2'h3 ##1 xo_force == 2'h3 |-> mdi_mode == 2'h1)
    else $error("forced crossed not applied");
endmodule
`default_nettype wire

// file: verification/pls_lp_model.sv
`timescale 1ns/1ps
`default_nettype none
module pls_lp_model
  import pls_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Scenario controls
  input wire logic plug,
  input wire logic neg,
  input wire logic loop_en,
  input wire logic xo,
  input wire logic cd,
  input wire logic [3:0] inv,
  input wire logic [5:0] adv,
  // Device transmit side
  input wire logic ipd_burst_tx,
  // Line status toward device
  output logic pma_link,
  output logic lp_an_seen,
  output logic flp_loop,
  output logic crossed_seen,
  output logic cd_swap_seen,
  output logic [3:0] pair_inv,
  output logic [5:0] lp_adv,
  output logic lp_master_req,
  output logic [1:0] pd_speed
);
  // Unpowered partner echoes the burst one cycle late, and only while it is sent
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flp_loop <= 1'b0;
    else
      flp_loop <= loop_en & ipd_burst_tx;
  end
  // Cable and partner state; energy and pulses are independent on purpose
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pma_link <= 1'b0;
      lp_an_seen <= 1'b0;
    end
    else
    begin
      pma_link <= plug;
      lp_an_seen <= neg;
    end
  end
  // Wiring faults and abilities seen on the line
  assign crossed_seen = xo;
  assign cd_swap_seen = cd;
  assign pair_inv = inv;
  assign lp_adv = adv;
  assign lp_master_req = 1'b0;
  assign pd_speed = SPD_100;
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pls_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic strap = 1'b1;
  logic plug = 1'b0, neg = 1'b0, loop_en = 1'b0, xo = 1'b0, cd = 1'b0;
  logic [3:0] inv = 4'h0;
  logic [5:0] adv = 6'h3f;
  logic [15:0] rdata, d;
  logic mgmt_int, pma_link, lp_an_seen, flp_loop, crossed_seen, cd_swap_seen;
  logic [3:0] pair_inv, pol_fix;
  logic [5:0] lp_adv;
  logic lp_master_req, an_flp_tx, ipd_burst_tx, master, mac_rgmii, mac_fd, link_up;
  logic [1:0] pd_speed, mdi_mode, mac_speed, rx_imp_sel;
  logic port_pwr = 1'b0;
  int n_mismatch = 0;
  int check_count = 0;

  // Short counts keep detection and downshift within a few dozen cycles
  pls_core #(.IPD_TIMEOUT(20), .ATTEMPT_TIME(8), .DS_COUNT(2)) i_pls_core (.clk_sys, .rstn,
    .addr, .wdata, .wr, .rd, .rdata, .mgmt_int, .pma_link, .lp_an_seen, .flp_loop,
    .crossed_seen, .cd_swap_seen, .pair_inv, .lp_adv, .lp_master_req, .pd_speed,
    .mac_rgmii_strap(strap), .an_flp_tx, .ipd_burst_tx, .mdi_mode, .pol_fix, .master,
    .mac_rgmii, .mac_speed, .mac_fd, .rx_imp_sel, .link_up);
  pls_lp_model i_pls_lp_model (.clk_sys, .rstn, .plug, .neg, .loop_en, .xo, .cd, .inv,
    .adv, .ipd_burst_tx, .pma_link, .lp_an_seen, .flp_loop, .crossed_seen,
    .cd_swap_seen, .pair_inv, .lp_adv, .lp_master_req, .pd_speed);

  always #25 clk_sys = ~clk_sys;

  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Let n edges pass and step off the edge so registered outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask

  // Read data follows the address one cycle later; the strobe only clears status
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic mwr(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m);
    logic [15:0] cur;
    rd_reg(a, cur);
    wr_reg(a, (cur & ~m) | (v & m));
  endtask

  task automatic t_reset();
    rd_reg(REG_CTL, d);
    chk(d, CTL_RST, "ctl reset");
    rd_reg(REG_XO_CTL, d);
    chk(d & 16'h0030, 16'h0000, "xover ctl reset");
    rd_reg(REG_XO_TEST, d);
    chk(d, 16'h0000, "unmapped read");
    chk({14'h0, rx_imp_sel}, {14'h0, IMP_RST}, "imp reset");
    chk({15'h0, mac_rgmii}, 16'h0001, "strap");
    chk({14'h0, an_flp_tx, mgmt_int}, 16'h0002, "reset outputs");
  endtask

  task automatic t_imp();
    wr_reg(REG_PAGE, PAGE_EXT);
    wr_reg(REG_IMP, 16'hc000);
    w(1);
    chk({14'h0, rx_imp_sel}, 16'h0003, "imp select");
    wr_reg(REG_IMP, 16'h0000);
    wr_reg(REG_PAGE, PAGE_STD);
  endtask

  task automatic t_link();
    plug = 1'b1;
    w(6);
    chk({13'h0, link_up, mac_speed}, {13'h0, 1'b1, SPD_100}, "parallel detect");
    chk({15'h0, mac_fd}, 16'h0000, "pd half duplex");
    plug = 1'b0;
    w(6);
    plug = 1'b1;
    neg = 1'b1;
    w(8);
    chk({12'h0, link_up, master, mac_fd, 1'b0}, 16'h000e, "negotiated");
    chk({14'h0, mac_speed}, {14'h0, SPD_1000}, "best speed");
    rd_reg(REG_STAT, d);
    chk(d & 16'h0004, 16'h0004, "link bit");
  endtask

  task automatic t_detect();
    wr_reg(REG_PAGE, PAGE_EXT);
    wr_reg(REG_IPD, 16'h0400);
    plug = 1'b0;
    neg = 1'b0;
    w(5);
    chk({14'h0, link_up, ipd_burst_tx}, 16'h0001, "loss enters detect");
    port_pwr = link_up;
    rd_reg(REG_IPD, d);
    chk(d & 16'h0300, 16'h0000, "searching");
    loop_en = 1'b1;
    w(6);
    rd_reg(REG_IPD, d);
    chk(d & 16'h0300, 16'h0100, "found");
    port_pwr = (d[9:8] == 2'h1);
    loop_en = 1'b0;
    chk({15'h0, mgmt_int}, 16'h0000, "pin disabled");
    wr_reg(REG_PAGE, PAGE_STD);
    wr_reg(REG_INT_EN, 16'h8000);
    w(1);
    chk({15'h0, mgmt_int}, 16'h0001, "pin enabled");
    rd_reg(REG_INT_STAT, d);
    chk(d & 16'h0200, 16'h0200, "int status");
    chk({15'h0, mgmt_int}, 16'h0000, "int dropped");
    rd_reg(REG_INT_STAT, d);
    chk(d & 16'h0200, 16'h0000, "clear on read");
  endtask

  task automatic t_timeout();
    plug = 1'b1;
    neg = 1'b1;
    w(8);
    plug = 1'b0;
    w(40);
    wr_reg(REG_PAGE, PAGE_EXT);
    rd_reg(REG_IPD, d);
    chk(d & 16'h0300, 16'h0200, "no device");
    chk({14'h0, an_flp_tx, ipd_burst_tx}, 16'h0002, "back to negotiation");
    wr_reg(REG_PAGE, PAGE_STD);
  endtask

  task automatic t_xover();
    xo = 1'b1;
    cd = 1'b1;
    inv = 4'ha;
    wr_reg(REG_PAGE, PAGE_XO);
    mwr(REG_XO_TEST, 16'h0018, 16'h0018);
    w(4);
    chk({14'h0, mdi_mode}, 16'h0001, "forced crossed");
    mwr(REG_XO_TEST, 16'h0010, 16'h0018);
    w(4);
    chk({14'h0, mdi_mode}, 16'h0000, "forced straight");
    mwr(REG_XO_TEST, 16'h0000, 16'h0018);
    wr_reg(REG_PAGE, PAGE_STD);
    w(4);
    chk({14'h0, mdi_mode}, 16'h0003, "auto crossed swap");
    chk({12'h0, pol_fix}, 16'h000a, "polarity fix");
    rd_reg(REG_XO_STAT, d);
    chk(d & 16'h3f00, 16'h3a00, "xover status");
    wr_reg(REG_XO_CTL, 16'h0010);
    w(4);
    chk({12'h0, pol_fix}, 16'h0000, "polarity fix off");
    wr_reg(REG_XO_CTL, 16'h0000);
  endtask

  task automatic t_force();
    logic [15:0] cv [3] = '{16'h0000, 16'h2100, 16'h0140};
    logic [1:0] sp [3] = '{SPD_10, SPD_100, SPD_1000};
    plug = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(REG_CTL, cv[i]);
      w(6);
      chk({13'h0, an_flp_tx, mac_speed}, {14'h0, sp[i]}, "forced speed");
      chk({15'h0, mac_fd}, {15'h0, i != 0}, "forced duplex");
    end
  endtask

  task automatic t_downshift();
    plug = 1'b0;
    neg = 1'b1;
    wr_reg(REG_PAGE, PAGE_EXT);
    wr_reg(REG_DS, 16'h0010);
    wr_reg(REG_PAGE, PAGE_STD);
    wr_reg(REG_CTL, CTL_RST);
    w(80);
    wr_reg(REG_PAGE, PAGE_EXT);
    rd_reg(REG_DS, d);
    chk(d & 16'h0002, 16'h0002, "downshift done");
    plug = 1'b1;
    w(8);
    chk({13'h0, link_up, mac_speed}, {13'h0, 1'b1, SPD_100}, "downshifted");
  endtask

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    w(1);
    t_reset();
    t_imp();
    t_link();
    t_detect();
    t_timeout();
    t_xover();
    t_force();
    t_downshift();
    conclude();
  end
endmodule
`default_nettype wire
